// ---- hw/port1_pkg.sv ----
// Package for the port 1 pin function block: register map, reset values and pin state types.
// Assumes a single 100 MHz clock domain and word-aligned AHB-Lite register access.
package port1_pkg;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_OUTPUT_LATCH = 16'h7F44;
  localparam logic [15:0] IDX_PIN_INPUT    = 16'h7F45;
  localparam logic [15:0] IDX_DIRECTION    = 16'h7F46;
  localparam logic [15:0] IDX_FUNC_SEL_A   = 16'h7F47;
  localparam logic [15:0] IDX_FUNC_SEL_B   = 16'h7FF1;

  localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] RST_DIRECTION    = 8'h00;
  localparam logic [7:0] RST_FUNC_SEL_A   = 8'h00;
  localparam logic [7:0] RST_FUNC_SEL_B   = 8'h00;

  localparam int PORT_WIDTH  = 8;
  localparam int SER_DATA_IN_PIN = 1;
  localparam int SER_CLK_PIN = 2;

  // Electrical state of one pin.
  typedef struct packed {
    logic drive_en;
    logic drive_val;
    logic pull_up;
    logic slow;
    logic inv_read;
  } pin_state_t;

  // Decodes the four control bits of one pin and its alternate function output.
  function automatic pin_state_t pin_decode(input logic fsa,
                                            input logic fsb,
                                            input logic lat,
                                            input logic ddr,
                                            input logic alt);
    pin_state_t s;
    s = '0;
    unique case ({fsa, fsb, lat, ddr})
      4'b0000: s = '0;
      4'b0010: s.pull_up = 1'b1;
      4'b0001: s.drive_en = 1'b1;
      4'b0011: s = '{drive_en: 1'b1, drive_val: 1'b1, default: 1'b0};
      4'b0100: s = '{drive_en: 1'b1, slow: 1'b1, default: 1'b0};
      4'b0110: s = '{drive_en: 1'b1, drive_val: 1'b1, slow: 1'b1, default: 1'b0};
      4'b0101: s.drive_en = 1'b1;
      4'b0111: s.inv_read = 1'b1;
      4'b1000: s.drive_en = 1'b1;
      4'b1010: s = '{drive_en: 1'b1, drive_val: ~alt, inv_read: 1'b1, default: 1'b0};
      4'b1001: s = '{drive_en: 1'b1, drive_val: alt, default: 1'b0};
      4'b1011: s = '{drive_en: 1'b1, drive_val: 1'b1, default: 1'b0};
      4'b1100: s = '{drive_en: 1'b1, slow: 1'b1, default: 1'b0};
      4'b1110: s = '{drive_en: 1'b1, drive_val: alt, slow: 1'b1, default: 1'b0};
      4'b1101: s.drive_en = ~alt;
      4'b1111: s = '0;
    endcase
    return s;
  endfunction : pin_decode

endpackage : port1_pkg

// ---- hw/port1_pin_function_control.sv ----
// Port 1 pin function control: five byte registers on AHB-Lite and eight pin drivers.
// Assumes pins are resolved by the surroundings from level and output enable, and that
// the serial unit and the auxiliary function sources run on hclk.
`timescale 1ns/1ns

module port1_pin_function_control
  import port1_pkg::*;
#(
  parameter int HADDR_W = 32
)
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [HADDR_W-1:0]    haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire logic [PORT_WIDTH-1:0] pin_in,
  output logic      [PORT_WIDTH-1:0] pin_out,
  output logic      [PORT_WIDTH-1:0] pin_oe_n,
  output logic      [PORT_WIDTH-1:0] pin_pull_up,
  output logic      [PORT_WIDTH-1:0] pin_slow,
  input  wire logic                  ser_data_out,
  input  wire logic                  ser_clk_out,
  input  wire logic [PORT_WIDTH-1:3] aux_func_out,
  output logic                       ser_data_in,
  output logic                       ser_clk_in
);

  // The upper-bit check on haddr needs at least one bit above bit 17.
  if (HADDR_W < 19)
  begin : g_bad_haddr_w
    $error("HADDR_W too narrow for the register map.");
  end

  logic [PORT_WIDTH-1:0] port_output_latch_reg;
  logic [PORT_WIDTH-1:0] port_direction_reg;
  logic [PORT_WIDTH-1:0] function_select_a_reg;
  logic [PORT_WIDTH-1:0] function_select_b_reg;
  logic [PORT_WIDTH-1:0] sync1_reg;
  logic [PORT_WIDTH-1:0] sync2_reg;
  logic [PORT_WIDTH-1:0] inv_mask;
  logic [PORT_WIDTH-1:0] port_pin_input;
  logic [PORT_WIDTH-1:0] alt_out;
  pin_state_t            pin_state [PORT_WIDTH];
  logic                  data_phase_reg;
  logic                  wr_reg;
  logic [15:0]           idx_reg;
  logic                  idx_ok_reg;
  logic                  accept;
  logic [31:0]           rdata_next;

  // Only whole-word transfers are expected; hsize is accepted but not checked.
  assign accept = hsel && htrans[1] && hready && !data_phase_reg;

  // Pins arrive from outside the clock domain, so two flops come before any reader.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // One wait state lets the read data come from a flop and keeps writes ahead of reads.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_phase_reg <= 1'b0;
      wr_reg         <= 1'b0;
      idx_reg        <= '0;
      idx_ok_reg     <= 1'b0;
      hreadyout      <= 1'b1;
    end
    else if (accept)
    begin
      data_phase_reg <= 1'b1;
      wr_reg         <= hwrite;
      idx_reg        <= haddr[17:2];
      idx_ok_reg     <= (haddr[1:0] == 2'h0) && (haddr[HADDR_W-1:18] == '0);
      hreadyout      <= 1'b0;
    end
    else
    begin
      data_phase_reg <= 1'b0;
      hreadyout      <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_output_latch_reg <= RST_OUTPUT_LATCH;
      port_direction_reg    <= RST_DIRECTION;
      function_select_a_reg <= RST_FUNC_SEL_A;
      function_select_b_reg <= RST_FUNC_SEL_B;
    end
    else if (data_phase_reg && wr_reg && idx_ok_reg)
    begin
      unique case (idx_reg)
        IDX_OUTPUT_LATCH: port_output_latch_reg <= hwdata[7:0];
        IDX_DIRECTION:    port_direction_reg    <= hwdata[7:0];
        IDX_FUNC_SEL_A:   function_select_a_reg <= hwdata[7:0];
        IDX_FUNC_SEL_B:   function_select_b_reg <= hwdata[7:0];
        default:          ;
      endcase
    end
  end

  // Unmapped addresses read as zero; they and the read-only input address ignore writes.
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (idx_ok_reg)
    begin
      unique case (idx_reg)
        IDX_OUTPUT_LATCH: rdata_next[7:0] = port_output_latch_reg;
        IDX_PIN_INPUT:    rdata_next[7:0] = port_pin_input;
        IDX_DIRECTION:    rdata_next[7:0] = port_direction_reg;
        IDX_FUNC_SEL_A:   rdata_next[7:0] = function_select_a_reg;
        IDX_FUNC_SEL_B:   rdata_next[7:0] = function_select_b_reg;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (data_phase_reg && !wr_reg)
      hrdata <= rdata_next;
  end

  assign alt_out = {aux_func_out, ser_clk_out, ser_data_out, ser_data_out};

  genvar g;
  generate
    for (g = 0; g < PORT_WIDTH; g++)
    begin : g_pin
      assign pin_state[g] = pin_decode(function_select_a_reg[g], function_select_b_reg[g],
                                       port_output_latch_reg[g], port_direction_reg[g],
                                       alt_out[g]);
      assign inv_mask[g] = pin_state[g].inv_read;

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          pin_out[g]     <= 1'b0;
          pin_oe_n[g]    <= 1'b1;
          pin_pull_up[g] <= 1'b0;
          pin_slow[g]    <= 1'b0;
        end
        else
        begin
          pin_out[g]     <= pin_state[g].drive_val;
          pin_oe_n[g]    <= ~pin_state[g].drive_en;
          pin_pull_up[g] <= pin_state[g].pull_up;
          pin_slow[g]    <= pin_state[g].slow;
        end
      end
    end
  endgenerate

  // Reads see the synchronised pin in every mode, complemented where the mode says so.
  assign port_pin_input = sync2_reg ^ inv_mask;

  // While function select A is set, the serial inputs follow the pin, with the same inversion as the pin read; otherwise they are low.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ser_data_in <= 1'b0;
      ser_clk_in  <= 1'b0;
    end
    else
    begin
      ser_data_in <= function_select_a_reg[SER_DATA_IN_PIN] &&
                     port_pin_input[SER_DATA_IN_PIN];
      ser_clk_in  <= function_select_a_reg[SER_CLK_PIN] &&
                     port_pin_input[SER_CLK_PIN];
    end
  end

  a_latch_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    data_phase_reg && wr_reg && idx_ok_reg && idx_reg == IDX_OUTPUT_LATCH
    |=> port_output_latch_reg == $past(hwdata[7:0]))
    else $error("Output latch did not take the written byte.");

  a_input_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    accept && !hwrite && haddr[17:0] == {IDX_PIN_INPUT, 2'h0} && haddr[HADDR_W-1:18] == '0
    |=> !hreadyout ##1 hreadyout && hrdata == {24'h00_0000, $past(port_pin_input)})
    else $error("Input address read returned wrong data or timing.");

  a_inverted_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_b_reg[0] && !function_select_a_reg[0] &&
    port_output_latch_reg[0] && port_direction_reg[0]
    |-> port_pin_input[0] == ~sync2_reg[0])
    else $error("Inverted read on pin zero not complemented.");

  a_read_any_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    port_pin_input == (sync2_reg ^ ((~function_select_a_reg & function_select_b_reg &
                                     port_output_latch_reg & port_direction_reg) |
                                    (function_select_a_reg & ~function_select_b_reg &
                                     port_output_latch_reg & ~port_direction_reg))))
    else $error("Pin read differs from synchronised pin level.");

  a_dir_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    data_phase_reg && wr_reg && idx_ok_reg && idx_reg == IDX_DIRECTION
    |=> port_direction_reg == $past(hwdata[7:0])
        ##1 (((~pin_oe_n ^ $past(port_direction_reg)) & ~function_select_a_reg &
              ~function_select_b_reg) == 8'h00))
    else $error("Direction register did not take the written byte.");

  a_fsb_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    data_phase_reg && wr_reg && idx_ok_reg && idx_reg == IDX_FUNC_SEL_B
    |=> function_select_b_reg == $past(hwdata[7:0]) && $stable(function_select_a_reg))
    else $error("Function select B write wrong or disturbed A.");

  a_open_drain: assert property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_a_reg[1] && function_select_b_reg[1] &&
    !port_output_latch_reg[1] && port_direction_reg[1]
    |=> pin_oe_n[1] == $past(ser_data_out) && !pin_out[1])
    else $error("Pin one not open-drain serial data.");

  a_serial_feed: assert property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_a_reg[1] && !function_select_b_reg[1] &&
    port_output_latch_reg[1] && !port_direction_reg[1]
    |=> ser_data_in == !$past(sync2_reg[1]))
    else $error("Serial data input not inverted in inverted mode.");

  a_plain_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !function_select_a_reg[0] && !function_select_b_reg[0] &&
    port_output_latch_reg[0] && !port_direction_reg[0]
    |=> pin_pull_up[0] && pin_oe_n[0])
    else $error("Pin zero pull-up mode wrong.");

  a_alt_push_pull: assert property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_a_reg[0] && !function_select_b_reg[0] &&
    !port_output_latch_reg[0] && port_direction_reg[0]
    |=> !pin_oe_n[0] && pin_out[0] == $past(ser_data_out))
    else $error("Pin zero push-pull serial data wrong.");

  a_clock_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_a_reg[2] && !function_select_b_reg[2] &&
    !port_output_latch_reg[2] && port_direction_reg[2]
    |=> pin_out[2] == $past(ser_clk_out) && !pin_oe_n[2])
    else $error("Pin two does not carry the serial clock.");

  c_read_input: cover property (
    @(posedge hclk) disable iff (!hresetn)
    data_phase_reg && !wr_reg && idx_reg == IDX_PIN_INPUT);

  c_write_fsa: cover property (
    @(posedge hclk) disable iff (!hresetn)
    data_phase_reg && wr_reg && idx_reg == IDX_FUNC_SEL_A);

  c_open_drain_low: cover property (
    @(posedge hclk) disable iff (!hresetn)
    function_select_a_reg[0] && function_select_b_reg[0] && !pin_oe_n[0]);

  c_inverted: cover property (
    @(posedge hclk) disable iff (!hresetn)
    inv_mask != 8'h00);

endmodule : port1_pin_function_control

// ---- tb/port1_pin_partner.sv ----
// Partner model: the board wiring that sits on the eight port pins.
// Assumes the design's pin outputs and the bench's external drivers, all on hclk.
`timescale 1ns/1ns
module port1_pin_partner
  import port1_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic [PORT_WIDTH-1:0] pin_out,
  input  wire logic [PORT_WIDTH-1:0] pin_oe_n,
  input  wire logic [PORT_WIDTH-1:0] pin_pull_up,
  input  wire logic [PORT_WIDTH-1:0] ext_val,
  input  wire logic [PORT_WIDTH-1:0] ext_en,
  output logic      [PORT_WIDTH-1:0] pin_in
);
  logic flip = 1'b0;

  // A pin left open wanders, so the simulator cannot settle it kindly.
  always @(posedge hclk)
    flip <= ~flip;

  always_comb
    for (int i = 0; i < PORT_WIDTH; i++)
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pin_pull_up[i] ? 1'b1 : flip;
endmodule : port1_pin_partner

// ---- tb/port1_pin_function_control_tb_top.sv ----
// Self-checking bench for the port 1 pin function block.
// Assumes one AHB-Lite master here, the pin partner model and a 100 MHz hclk.
`timescale 1ns/1ns
module port1_pin_function_control_tb_top;
  import port1_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pull_up, pin_slow;
  logic [7:0]  ext_val = 8'h00;
  logic [7:0]  ext_en = 8'h00;
  logic        ser_data_out = 1'b0;
  logic        ser_clk_out = 1'b0;
  logic [7:3]  aux_func_out = 5'h00;
  logic        ser_data_in, ser_clk_in;
  int          failures = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [15:0] idx [4] = '{IDX_OUTPUT_LATCH, IDX_DIRECTION, IDX_FUNC_SEL_A, IDX_FUNC_SEL_B};

  port1_pin_function_control u_port1_pin_function_control (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pull_up(pin_pull_up), .pin_slow(pin_slow), .ser_data_out(ser_data_out),
    .ser_clk_out(ser_clk_out), .aux_func_out(aux_func_out), .ser_data_in(ser_data_in),
    .ser_clk_in(ser_clk_in));
  port1_pin_partner u_port1_pin_partner (.hclk(hclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));

  always #5 hclk = ~hclk;

  task automatic stop_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Long enough for 48 passes of about 32 cycles each, with a wide margin.
  always @(posedge hclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      stop_test;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [15:0] ix, input logic [7:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0, ix, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask : bus

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr

  // Result is {release, level, pull-up, slow, inverted read} for one pin.
  function automatic logic [4:0] ref_pin(input logic [3:0] m, input logic alt);
    case (m)
      4'h0, 4'hF: return 5'b10000;
      4'h2: return 5'b10100;
      4'h3, 4'hB: return 5'b01000;
      4'h4, 4'hC: return 5'b00010;
      4'h6: return 5'b01010;
      4'h7: return 5'b10001;
      4'hA: return {1'b0, ~alt, 3'b001};
      4'h9: return {1'b0, alt, 3'b000};
      4'hE: return {1'b0, alt, 3'b010};
      4'hD: return {alt, 4'b0000};
      default: return 5'b00000;
    endcase
  endfunction : ref_pin

  initial
  begin
    logic [31:0] lf, rd;
    logic [7:0]  v [4];
    logic [7:0]  eoe, eout, epu, esl, erd, known;
    logic [4:0]  e;
    logic        alt, lvl;
    lf = 32'hA47B4690;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int j = 0; j < 4; j++)
    begin
      bus(1'b0, idx[j], 8'h00, rd);
      check(rd, 32'h0);
    end
    bus(1'b0, 16'h7F48, 8'h00, rd);
    check(rd, 32'h0);
    for (int k = 0; k < 48; k++)
    begin
      // The first sixteen passes put every pin in each of the sixteen modes.
      if (k < 16)
        v = '{{8{k[1]}}, {8{k[0]}}, {8{k[3]}}, {8{k[2]}}};
      else
        for (int j = 0; j < 4; j++)
        begin
          lf = lfsr(lf);
          v[j] = lf[7:0];
        end
      lf = lfsr(lf);
      ext_val <= lf[7:0];
      ext_en <= lf[15:8] | 8'h06;
      ser_data_out <= lf[16];
      ser_clk_out <= lf[17];
      aux_func_out <= lf[22:18];
      for (int j = 0; j < 4; j++)
        bus(1'b1, idx[j], v[j], rd);
      repeat (5) @(posedge hclk);
      for (int i = 0; i < 8; i++)
      begin
        alt = (i < 2) ? ser_data_out : (i == 2) ? ser_clk_out : aux_func_out[i];
        e = ref_pin({v[2][i], v[3][i], v[0][i], v[1][i]}, alt);
        {eoe[i], eout[i], epu[i], esl[i]} = e[4:1];
        lvl = !e[4] ? e[3] : ext_en[i] ? ext_val[i] : e[2];
        known[i] = !e[4] | ext_en[i] | e[2];
        erd[i] = lvl ^ e[0];
      end
      check(32'(pin_oe_n), 32'(eoe));
      check(32'(pin_out & ~eoe), 32'(eout & ~eoe));
      check(32'(pin_pull_up), 32'(epu));
      check(32'(pin_slow), 32'(esl));
      check(32'(ser_data_in), 32'(v[2][1] & erd[1]));
      check(32'(ser_clk_in), 32'(v[2][2] & erd[2]));
      bus(1'b0, IDX_PIN_INPUT, 8'h00, rd);
      check(rd & 32'(known), 32'(erd & known));
      for (int j = 0; j < 4; j++)
      begin
        bus(1'b0, idx[j], 8'h00, rd);
        check(rd, 32'(v[j]));
      end
    end
    // A reset in mid-run must bring every register and pin driver back to idle.
    hresetn <= 1'b0;
    @(posedge hclk);
    check(32'(pin_oe_n), 32'h0000_00FF);
    check(32'(pin_pull_up), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int j = 0; j < 4; j++)
    begin
      bus(1'b0, idx[j], 8'h00, rd);
      check(rd, 32'h0);
    end
    stop_test;
  end
endmodule : port1_pin_function_control_tb_top
